// File: ppio_pkg.sv
// package for the six-bit port block: register map, field layout, reset values
// assumes a classic wishbone slave with 32-bit data and word-aligned registers
// Notes on behaviour
// - gpio output drives latch bit to pin
// - latch read: latch if output, else pin
// - unclaimed pins are plain latch/direction gpio
// - bit 1 pin carries nonmaskable interrupt input
// - nonmaskable enabled when cpu clears mask bit
// - first mask clear forces bit 1 input forever
// - nonmaskable beats pwm and gpio on bit 1
// - no stop/wait wake while mask set
// - enabled pwm channel overrides gpio
// - pwm forces output, direction bit unchanged
// - bit 5 interrupt forces input, direction kept
// - direction 1 is output, 0 input
// - input view reads pins, ignores writes
// - pin-change interrupts in input or output mode
// - polarity 1 rising edge, 0 falling
// - per-pin enable masks the interrupt
package ppio_pkg;
    localparam int          PPIO_NPIN      = 6;
    localparam logic [7:0]  PPIO_OFS_LATCH = 8'h00;
    localparam logic [7:0]  PPIO_OFS_VIEW  = 8'h04;
    localparam logic [7:0]  PPIO_OFS_DIR   = 8'h08;
    localparam logic [7:0]  PPIO_OFS_POL   = 8'h0C;
    localparam logic [7:0]  PPIO_OFS_IEN   = 8'h10;
    localparam logic [7:0]  PPIO_OFS_FLAG  = 8'h14;
    localparam logic [7:0]  PPIO_OFS_CLR   = 8'h18;
    localparam logic [7:0]  PPIO_OFS_CTRL  = 8'h1C;
    localparam logic [7:0]  PPIO_OFS_STAT  = 8'h20;
    localparam int          PPIO_NMI_BIT   = 1;
    localparam int          PPIO_EXT_BIT   = 5;
    localparam int          PPIO_CTRL_EXTEN = 0;
    localparam int          PPIO_CTRL_NMASK = 1;
    localparam int          PPIO_STAT_NMIEN = 0;
    localparam int          PPIO_STAT_WAKE  = 1;
    localparam logic [5:0]  PPIO_RST_LATCH = 6'h00;
    localparam logic [5:0]  PPIO_RST_DIR   = 6'h00;
    localparam logic [5:0]  PPIO_RST_POL   = 6'h00;
    localparam logic [5:0]  PPIO_RST_IEN   = 6'h00;
    localparam logic [1:0]  PPIO_RST_CTRL  = 2'h2;
    localparam logic [5:0]  PPIO_RST_OE_N  = 6'h3F;
endpackage : ppio_pkg

// File: ppio_sync.sv
// two-flop synchroniser for a vector of pin levels
// assumes pins are asynchronous to CLOCK_I
`timescale 1ns/1ps
`default_nettype none
module ppio_sync
    import ppio_pkg::*;
#(
    parameter int W = PPIO_NPIN
)(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ppio_sync_t;

    ppio_sync_t st_r;
    ppio_sync_t st_nxt;

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.s2;
endmodule // ppio_sync
`default_nettype wire

// File: ppio_port.sv
// six-bit port: latch, direction, input view, alternate-function priority, pin-change irq
// assumes classic wishbone master on CLOCK_I; pins and cpu mask come from outside
`timescale 1ns/1ps
`default_nettype none
module ppio_port
    import ppio_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic [5:0]  PIN_I,
    output logic      [5:0]  PIN_O,
    output logic      [5:0]  PIN_OE_N_O,
    input  wire logic [5:0]  PWM_EN_I,
    input  wire logic [5:0]  PWM_I,
    input  wire logic        CPU_NMASK_I,
    output logic             NONMASKABLE_INTERRUPT_LINE_O,
    output logic             EXT_IRQ_O,
    output logic             WAKE_ALLOW_O,
    output logic             IRQ_O
);
    typedef struct packed {
        logic [5:0]  latch;
        logic [5:0]  dir;
        logic [5:0]  pol;
        logic [5:0]  ien;
        logic [5:0]  flag;
        logic [5:0]  pin_d;
        logic        ext_en;
        logic        nmask_sw;
        logic        nmi_on;
        logic        ack;
        logic [31:0] rdata;
        logic [5:0]  pout;
        logic [5:0]  poe_n;
    } ppio_state_t;

    ppio_state_t st_r;
    ppio_state_t st_nxt;
    logic [5:0]  pin_s;
    logic [5:0]  edge_hit;
    logic [5:0]  force_in;
    logic [5:0]  force_out;
    logic [5:0]  latch_rd;
    logic        wr_stb;
    logic        rd_stb;
    logic        nmask;
    logic [5:0]  nxt_oe_n;
    logic [5:0]  nxt_out;

    ppio_sync #(
        .W (PPIO_NPIN)
    ) ppio_sync_inst (
        .clk_i (CLOCK_I),
        .rst_i (RST_I),
        .d_i   (PIN_I),
        .q_o   (pin_s)
    );

    // mask holds only while cpu and software mirror both set it
    assign nmask  = CPU_NMASK_I & st_r.nmask_sw;
    // write lands at the ack edge, while the master still holds it
    assign wr_stb = CYC_I & STB_I & WE_I & st_r.ack & SEL_I[0];
    assign rd_stb = CYC_I & STB_I & ~WE_I & ~st_r.ack;

    genvar g;
    generate
        for (g = 0; g < PPIO_NPIN; g++)
        begin : g_pin
            assign edge_hit[g] = st_r.pol[g] ? (pin_s[g] & ~st_r.pin_d[g])
                                             : (~pin_s[g] & st_r.pin_d[g]);
            if (g == PPIO_NMI_BIT)
            begin : g_nmi
                assign force_in[g] = st_r.nmi_on;
            end
            else if (g == PPIO_EXT_BIT)
            begin : g_ext
                assign force_in[g] = st_r.ext_en;
            end
            else
            begin : g_gp
                assign force_in[g] = 1'b0;
            end
            assign force_out[g] = PWM_EN_I[g] & ~force_in[g];
            assign nxt_oe_n[g] = force_in[g] ? 1'b1 :
                                 force_out[g] ? 1'b0 : ~st_r.dir[g];
            assign nxt_out[g]  = force_out[g] ? PWM_I[g] : st_r.latch[g];
            // latch read source depends on direction
            assign latch_rd[g] = st_r.dir[g] ? st_r.latch[g] : pin_s[g];
        end
    endgenerate

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.pin_d = pin_s;
        st_nxt.ack   = CYC_I & STB_I & ~st_r.ack;
        st_nxt.pout  = nxt_out;
        st_nxt.poe_n = nxt_oe_n;
        // first mask clear latches input forever
        if (!nmask)
        begin
            st_nxt.nmi_on = 1'b1;
        end
        if (wr_stb)
        begin
            case (ADR_I)
                PPIO_OFS_LATCH: st_nxt.latch = DAT_I[5:0];
                PPIO_OFS_DIR:   st_nxt.dir   = DAT_I[5:0];
                PPIO_OFS_POL:   st_nxt.pol   = DAT_I[5:0];
                PPIO_OFS_IEN:   st_nxt.ien   = DAT_I[5:0];
                PPIO_OFS_CLR:   st_nxt.flag  = st_r.flag & ~DAT_I[5:0];
                PPIO_OFS_CTRL:
                begin
                    st_nxt.ext_en   = DAT_I[PPIO_CTRL_EXTEN];
                    st_nxt.nmask_sw = DAT_I[PPIO_CTRL_NMASK];
                end
                default: st_nxt.latch = st_r.latch;
            endcase
        end
        // set wins over a same-cycle clear
        st_nxt.flag = st_nxt.flag | edge_hit;
        st_nxt.rdata = 32'h0000_0000;
        if (rd_stb)
        begin
            case (ADR_I)
                PPIO_OFS_LATCH: st_nxt.rdata[5:0] = latch_rd;
                PPIO_OFS_VIEW:  st_nxt.rdata[5:0] = pin_s;
                PPIO_OFS_DIR:   st_nxt.rdata[5:0] = st_r.dir;
                PPIO_OFS_POL:   st_nxt.rdata[5:0] = st_r.pol;
                PPIO_OFS_IEN:   st_nxt.rdata[5:0] = st_r.ien;
                PPIO_OFS_FLAG:  st_nxt.rdata[5:0] = st_r.flag;
                PPIO_OFS_CTRL:  st_nxt.rdata[1:0] = {st_r.nmask_sw, st_r.ext_en};
                PPIO_OFS_STAT:  st_nxt.rdata[1:0] = {~nmask, st_r.nmi_on};
                default:        st_nxt.rdata      = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            st_r          <= '0;
            st_r.latch    <= PPIO_RST_LATCH;
            st_r.dir      <= PPIO_RST_DIR;
            st_r.pol      <= PPIO_RST_POL;
            st_r.ien      <= PPIO_RST_IEN;
            st_r.ext_en   <= PPIO_RST_CTRL[PPIO_CTRL_EXTEN];
            st_r.nmask_sw <= PPIO_RST_CTRL[PPIO_CTRL_NMASK];
            st_r.poe_n    <= PPIO_RST_OE_N;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign DAT_O      = st_r.rdata;
    assign ACK_O      = st_r.ack;
    assign PIN_O      = st_r.pout;
    assign PIN_OE_N_O = st_r.poe_n;
    // bit 1 pin routed to nonmaskable line
    assign NONMASKABLE_INTERRUPT_LINE_O = st_r.nmi_on & pin_s[PPIO_NMI_BIT];
    assign EXT_IRQ_O  = st_r.ext_en & pin_s[PPIO_EXT_BIT];
    assign WAKE_ALLOW_O = ~nmask;
    assign IRQ_O = |(st_r.flag & st_r.ien);

    AST_NMI_STICKY: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        st_r.nmi_on |=> st_r.nmi_on) else $error("nonmaskable input dropped");

    // first clear forces bit 1 input
    AST_NMI_INPUT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !nmask |-> ##2 PIN_OE_N_O[PPIO_NMI_BIT]) else $error("bit 1 not input");

    AST_PWM_OUT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (PWM_EN_I[0] && $stable(PWM_EN_I[0])) |=> !PIN_OE_N_O[0])
        else $error("pwm pin not output");

    // ext irq forces bit 5 input
    AST_EXT_INPUT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        st_r.ext_en |=> PIN_OE_N_O[PPIO_EXT_BIT]) else $error("bit 5 not input");

    AST_DIR_KEPT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !(wr_stb && ADR_I == PPIO_OFS_DIR) |=> $stable(st_r.dir))
        else $error("direction changed");

    sequence s_edge;
        st_r.pol[1] && !st_r.pin_d[1] && pin_s[1];
    endsequence
    AST_EDGE_FLAG: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        s_edge |=> st_r.flag[1]) else $error("edge flag missed");

    AST_IEN_MASK: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (st_r.ien == 6'h00) |-> !IRQ_O) else $error("masked irq raised");

    AST_WAKE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        nmask |-> !WAKE_ALLOW_O) else $error("wake allowed under mask");

    AST_GPIO_OUT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (st_r.dir[3] && !PWM_EN_I[3]) |=> PIN_O[3] == $past(st_r.latch[3]))
        else $error("gpio output wrong");

    sequence s_latch_rd;
        rd_stb && (ADR_I == PPIO_OFS_LATCH);
    endsequence
    AST_RD_LATCH: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        s_latch_rd ##0 st_r.dir[0] |=> DAT_O[0] == $past(st_r.latch[0]))
        else $error("latch read wrong");

    AST_RD_PIN: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        s_latch_rd ##0 !st_r.dir[0] |=> DAT_O[0] == $past(pin_s[0]))
        else $error("pin read wrong");

    AST_RD_VIEW: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (rd_stb && ADR_I == PPIO_OFS_VIEW) |=> DAT_O == {26'h0, $past(pin_s)})
        else $error("view read wrong");

    AST_VIEW_WR: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (wr_stb && ADR_I == PPIO_OFS_VIEW) |=> $stable(st_r.latch) && $stable(st_r.dir))
        else $error("view write took effect");

    AST_DIR_OUT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (st_r.dir[0] && !PWM_EN_I[0]) |=> !PIN_OE_N_O[0])
        else $error("output bit not driven");

    AST_DIR_IN: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (!st_r.dir[2] && !PWM_EN_I[2]) |=> PIN_OE_N_O[2])
        else $error("input bit driven");

    AST_GPIO_PLAIN: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !PWM_EN_I[4] |=> PIN_O[4] == $past(st_r.latch[4]))
        else $error("plain gpio value wrong");

    AST_GPIO_BIT0: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (st_r.dir[0] && !PWM_EN_I[0]) |=> PIN_O[0] == $past(st_r.latch[0]))
        else $error("bit 0 output wrong");

    AST_NMI_PRIO: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (st_r.nmi_on && PWM_EN_I[PPIO_NMI_BIT]) |=> PIN_OE_N_O[PPIO_NMI_BIT])
        else $error("pwm took nonmaskable pin");

    AST_PWM_VAL: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        PWM_EN_I[4] |=> PIN_O[4] == $past(PWM_I[4]))
        else $error("pwm value not on pin");

    AST_PWM_DIR: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        PWM_EN_I[2] |=> !PIN_OE_N_O[2])
        else $error("pwm bit 2 not output");

    AST_NMI_LINE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !st_r.nmi_on |-> !NONMASKABLE_INTERRUPT_LINE_O)
        else $error("nonmaskable line early");

    AST_NMI_ENABLE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !CPU_NMASK_I |=> st_r.nmi_on)
        else $error("nonmaskable not enabled");

    AST_NMI_HELD: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (nmask && !st_r.nmi_on) |=> !st_r.nmi_on)
        else $error("nonmaskable enabled under mask");

    AST_WAKE_OPEN: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !nmask |-> WAKE_ALLOW_O)
        else $error("wake blocked without mask");

    sequence s_mask_pulse;
        !nmask ##1 nmask;
    endsequence
    AST_NMI_KEPT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        s_mask_pulse |=> PIN_OE_N_O[PPIO_NMI_BIT])
        else $error("bit 1 left input mode");

    AST_STAT_NMI: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (rd_stb && ADR_I == PPIO_OFS_STAT) |=> DAT_O[PPIO_STAT_NMIEN] == $past(st_r.nmi_on))
        else $error("status read wrong");

    sequence s_out_rise;
        st_r.dir[3] && st_r.pol[3] && !st_r.pin_d[3] && pin_s[3];
    endsequence
    AST_OUT_EDGE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        s_out_rise |=> st_r.flag[3])
        else $error("output edge missed");

    sequence s_fall;
        !st_r.pol[0] && st_r.pin_d[0] && !pin_s[0];
    endsequence
    AST_FALL_FLAG: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        s_fall |=> st_r.flag[0])
        else $error("falling edge missed");

    AST_NO_EDGE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (!st_r.flag[0] && !edge_hit[0]) |=> !st_r.flag[0])
        else $error("flag without edge");

    sequence s_irq_edge;
        edge_hit[2] && st_r.ien[2] && !(wr_stb && ADR_I == PPIO_OFS_IEN);
    endsequence
    AST_IRQ_RAISE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        s_irq_edge |=> IRQ_O)
        else $error("enabled edge raised nothing");

    AST_FLAG_HOLD: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (st_r.flag[4] && !(wr_stb && ADR_I == PPIO_OFS_CLR)) |=> st_r.flag[4])
        else $error("flag dropped");

    // two stages from pin to use
    AST_SYNC_DELAY: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !$past(RST_I) |=> pin_s == $past(PIN_I, 2))
        else $error("synchroniser depth wrong");

    AST_IRQ_QUIET: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (st_r.flag == 6'h00) |-> !IRQ_O)
        else $error("request without flag");
endmodule // ppio_port
`default_nettype wire

// File: ppio_pin_model.sv
// partner model: external pin wiring, resolves each pin level from port drive
// assumes a low enable means the port drives the pin; else the outside source wins
`timescale 1ns/1ps
`default_nettype none
module ppio_pin_model (
    input  wire logic [5:0] pin_o_i,
    input  wire logic [5:0] oe_n_i,
    input  wire logic [5:0] ext_i,
    output logic      [5:0] pin_i_o
);
    assign pin_i_o = (pin_o_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule // ppio_pin_model
`default_nettype wire

// File: test_port_p_pin_io_control.sv
// bench for the six-bit port: wishbone tasks, reference model, pin scenarios
// assumes ppio_pkg, ppio_port and ppio_pin_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_port_p_pin_io_control
    import ppio_pkg::*;
;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, nmask = 1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, dout, q;
    logic        ack, nmi, ext_irq, wake, irq;
    logic [5:0]  pin_i, pin_o, oe_n, ext = 6'h00, pwm_en = 6'h00, pwm = 6'h00;
    logic [5:0]  lat = 6'h00, dir = 6'h00, eo, en, pv;
    int          failures = 0, samples_checked = 0, seed = 45;
    bit          nmi_on = 0, ext_on = 0;

    always #5 clk = ~clk;

    ppio_port ppio_port_inst (.CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dout), .ACK_O(ack),
        .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_N_O(oe_n), .PWM_EN_I(pwm_en), .PWM_I(pwm),
        .CPU_NMASK_I(nmask), .NONMASKABLE_INTERRUPT_LINE_O(nmi), .EXT_IRQ_O(ext_irq),
        .WAKE_ALLOW_O(wake), .IRQ_O(irq));
    ppio_pin_model ppio_pin_model_inst (.pin_o_i(pin_o), .oe_n_i(oe_n), .ext_i(ext),
        .pin_i_o(pin_i));

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until ack is sampled high, then released
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
        if (n >= 50)
            failures++;
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // reference drive: nonmaskable, then bit5 irq, then pwm, then gpio
    task automatic exp_pins();
        repeat (6) @(posedge clk);
        en = ~dir;
        eo = lat;
        for (int i = 0; i < 6; i++)
            if ((nmi_on && i == 1) || (ext_on && i == 5))
                en[i] = 1'b1;
            else if (pwm_en[i])
            begin
                en[i] = 1'b0;
                eo[i] = pwm[i];
            end
        pv = (eo & ~en) | (ext & en);
        chk(oe_n, en);
        chk(pin_o & ~en, eo & ~en);
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        exp_pins();
        rd(PPIO_OFS_CTRL, 32'h2);
        rd(8'hFC, 32'h0);
        repeat (20)
        begin
            lat = 6'($random(seed));
            dir = 6'($random(seed));
            ext <= 6'($random(seed));
            wb(1'b1, PPIO_OFS_LATCH, {26'h0, lat});
            wb(1'b1, PPIO_OFS_DIR, {26'h0, dir});
            wb(1'b1, PPIO_OFS_VIEW, 32'h3F);
            exp_pins();
            rd(PPIO_OFS_VIEW, {26'h0, pv});
            rd(PPIO_OFS_LATCH, {26'h0, (dir & lat) | (~dir & pv)});
        end
        // edge flags, polarity and enable gating
        dir = 6'h00;
        wb(1'b1, PPIO_OFS_DIR, 32'h0);
        ext <= 6'h00;
        wb(1'b1, PPIO_OFS_POL, 32'h2A);
        wb(1'b1, PPIO_OFS_IEN, 32'h0);
        wb(1'b1, PPIO_OFS_CLR, 32'h3F);
        ext <= 6'h3F;
        exp_pins();
        rd(PPIO_OFS_FLAG, 32'h2A);
        chk(irq, 1'b0);
        wb(1'b1, PPIO_OFS_IEN, 32'h3F);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wb(1'b1, PPIO_OFS_CLR, 32'h2A);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        ext <= 6'h00;
        exp_pins();
        rd(PPIO_OFS_FLAG, 32'h15);
        // output-mode edges still flag
        wb(1'b1, PPIO_OFS_CLR, 32'h3F);
        lat = 6'h00;
        wb(1'b1, PPIO_OFS_LATCH, 32'h0);
        dir = 6'h3F;
        wb(1'b1, PPIO_OFS_DIR, 32'h3F);
        exp_pins();
        wb(1'b1, PPIO_OFS_CLR, 32'h3F);
        lat = 6'h3F;
        wb(1'b1, PPIO_OFS_LATCH, 32'h3F);
        exp_pins();
        rd(PPIO_OFS_FLAG, 32'h2A);
        pwm_en <= 6'h3F;
        pwm <= 6'h15;
        exp_pins();
        rd(PPIO_OFS_DIR, {26'h0, dir});
        ext_on = 1'b1;
        ext <= 6'h20;
        wb(1'b1, PPIO_OFS_CTRL, 32'h3);
        exp_pins();
        chk(ext_irq, pv[5]);
        rd(PPIO_OFS_DIR, {26'h0, dir});
        chk(wake, 1'b0);
        nmask <= 1'b0;
        repeat (2) @(posedge clk);
        chk(wake, 1'b1);
        nmask <= 1'b1;
        nmi_on = 1'b1;
        ext <= 6'h02;
        exp_pins();
        chk(nmi, 1'b1);
        chk(wake, 1'b0);
        rd(PPIO_OFS_STAT, 32'h1);
        rd(PPIO_OFS_DIR, {26'h0, dir});
        final_report();
    end

    // hang guard, far beyond the expected run
    initial
    begin
        #500000;
        failures++;
        final_report();
    end
endmodule // test_port_p_pin_io_control
`default_nettype wire
